// ---- tb/acs_conv_model.sv ----
// Converter core stand-in giving a held dc level
// Assumes the bench sets the level between clock edges
`timescale 1ns/10ps
module acs_conv_model (
  input wire logic clk_i, // Clock
  input wire logic [15:0] level_i, // Input level
  output logic [15:0] data_o // Sample word
);
  always_ff @(posedge clk_i)
  begin
    data_o <= level_i;
  end
endmodule : acs_conv_model

// ---- tb/acs_properties.sv ----
// Checker on the ports of acs_channel
// Assumes it is bound to acs_channel and only watches
`timescale 1ns/10ps
module acs_properties (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Sync reset
  input wire logic [4:0] converter_config_word_i, // Select code
  input wire logic conv_enable_i, // Converter on
  input wire logic dc_phase_i, // Phase
  input wire logic [15:0] conv_data_i, // Raw sample
  input wire acs_pkg::acs_route_s route_o, // Routing
  input wire acs_pkg::acs_sample_s dft_sample_o, // To DFT
  input wire acs_pkg::acs_sample_s decim_sample_o, // Decimated
  input wire acs_pkg::acs_sample_s reject_sample_o // Line reject
);
  wire logic [4:0] cw = converter_config_word_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  property p_float; cw == 5'h00 |=> route_o == 12'h000; endproperty
  a_float: assert property (p_float) else $error("float");
  property p_tia; cw == 5'h02 |=> route_o == 12'h123; endproperty
  a_tia: assert property (p_tia) else $error("tia");
  property p_aux; cw inside {[5'h08:5'h0B]} |=>
    route_o == {7'h1B, 3'($past(cw) - 5'h08), 2'b01}; endproperty
  a_aux: assert property (p_aux) else $error("aux");
  property p_rail; cw inside {[5'h0D:5'h12]} |=>
    route_o == {7'h2B, 3'($past(cw) - 5'h0D), 2'b01}; endproperty
  a_rail: assert property (p_rail) else $error("rail");
  property p_res; cw inside {5'h01, [5'h04:5'h07], [5'h13:5'h17],
    5'h1B, 5'h1F} |=> route_o == 12'h000; endproperty
  a_res: assert property (p_res) else $error("reserved");
  property p_gain; 1'b1 |=> route_o.gain_1p5 ==
    ($past(cw) inside {5'h02, 5'h03, 5'h18, 5'h19, 5'h1A, 5'h1E});
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_gap; dft_sample_o.valid |=> !dft_sample_o.valid [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("dft rate");
  property p_dcq; dc_phase_i |-> ##2 !dft_sample_o.valid; endproperty
  a_dcq: assert property (p_dcq) else $error("dft in dc");
  property p_acq; !dc_phase_i [*8] |-> !decim_sample_o.valid;
  endproperty
  a_acq: assert property (p_acq) else $error("decim in ac");
endmodule : acs_properties
bind acs_channel acs_properties i_props (.clk_i, .reset_i,
  .converter_config_word_i, .conv_enable_i, .dc_phase_i, .conv_data_i,
  .route_o, .dft_sample_o, .decim_sample_o, .reject_sample_o);

// ---- tb/testbench.sv ----
// Bench: route sweep, ac and dc sample paths
// Assumes the converter stand-in and the bound checker
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("CHECK FAILED %0t ns: mismatch", $time); end end
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] sel = 5'h00;
  logic en = 1'b0;
  logic dc = 1'b0;
  logic [15:0] level = 16'h0000;
  logic [15:0] conv;
  acs_pkg::acs_route_s route;
  acs_pkg::acs_sample_s dft, dec, rej;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_rej = 0;
  int k;
  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) if (rej.valid === 1'b1) n_rej++;
  acs_conv_model i_conv (.clk_i(clk_i), .level_i(level), .data_o(conv));
  acs_channel i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .converter_config_word_i(sel), .conv_enable_i(en), .dc_phase_i(dc),
    .conv_data_i(conv), .route_o(route), .dft_sample_o(dft),
    .decim_sample_o(dec), .reject_sample_o(rej));
  function automatic logic [11:0] exp_route(input logic [4:0] c);
    case (c)
      5'h02: return 12'h123;
      5'h03: return 12'h243;
      5'h08, 5'h09, 5'h0A, 5'h0B: return {7'h1B, 1'b0, c[1:0], 2'b01};
      5'h0C: return 12'h461;
      5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12:
        return {7'h2B, 3'(c - 5'h0D), 2'b01};
      5'h18: return 12'h663;
      5'h19: return 12'h763;
      5'h1A: return 12'h843;
      5'h1C: return 12'h961;
      5'h1D: return 12'h761;
      5'h1E: return 12'hA83;
      default: return 12'h000;
    endcase
  endfunction : exp_route
  task wait_for(input int w, input int lim);
    k = 0;
    @(negedge clk_i);
    while ((w == 0 ? dft.valid : dec.valid) !== 1'b1 && k < lim)
    begin
      @(negedge clk_i);
      k++;
    end
  endtask : wait_for
  task t_routes;
    for (int c = 0; c < 32; c++)
    begin
      sel = 5'h00;
      @(negedge clk_i);
      sel = 5'(c);
      repeat (2) @(negedge clk_i);
      `CHK(route, exp_route(sel))
    end
  endtask : t_routes
  task t_ac;
    level = 16'h1234;
    en = 1'b1; // Reference taken as already enabled
    wait_for(0, 200);
    `CHK(dft.data, 16'h1234)
    wait_for(0, 200);
    `CHK(k, 61)
  endtask : t_ac
  task t_dc;
    level = 16'hA5A5;
    sel = 5'h0D;
    @(negedge clk_i);
    dc = 1'b1;
    // First decimated word comes long after settling
    wait_for(1, 12000);
    `CHK(dec.data, 16'hA5A5)
    wait_for(1, 12000);
    `CHK(k, 11035)
    `CHK(rej.data, 16'h0A5A)
    repeat (8) @(negedge clk_i);
    `CHK(n_rej, 2)
  endtask : t_dc
  task summarize;
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
    t_routes;
    t_ac;
    t_dc;
    summarize;
  end
  initial
  begin
    #3000000;
    n_mismatch++;
    summarize;
  end
endmodule : testbench

// ---- verilog/acs_channel.sv ----
// Converter channel select, gain and sample stream steering
// Assumes the converter core delivers raw samples on conv_*_i; the
// DFT engine and filter consumers take one-cycle valid strobes
//
// Behaviour
// [RL1] Zero code connects nothing; the channel floats.
// [RL2] Code 00010 routes transimpedance output and inverting node, gain 1.5.
// [RL3] Code 00011 routes thermal sensor positive and negative, gain 1.5.
// [RL4] Codes 01000 to 01011 route aux inputs A to D against bias, gain 1.
// [RL5] Code 01100 routes reference excitation output against bias, gain 1.
// [RL6] Codes 01101 to 10010 route six half supply rails against bias.
// [RL7] Codes 11000, 11001, 11010 route calibration pairs at gain 1.5.
// [RL8] Codes 11100, 11101 route zero or reference against bias, gain 1.
// [RL9] Code 11110 routes front-end positive and negative nodes, gain 1.5.
// [RL10] Unlisted codes behave as the floating state.
// [RL11] Gain follows from the select code alone.
// [RL12] Software holds zero code one clock before a new channel.
// [RL13] Software waits about 100 us after a change before using samples.
// [RL14] Converter delivers a continuous 16-bit stream at 160 kSPS; the strobe divides the 10 MHz clock by 62, about 161.3 kSPS.
// [RL15] In ac phase full-rate samples go to the DFT engine.
// [RL16] In dc phase samples are decimated by 178.
// [RL17] Decimated samples pass a power-line reject filter.
// [RL18] Software enables the precision reference before use.
`timescale 1ns/10ps
`include "acs_map.svh"
module acs_channel (
  input wire logic clk_i, // 10 MHz clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic [4:0] converter_config_word_i, // Select code
  input wire logic conv_enable_i, // Converter running
  input wire logic dc_phase_i, // 1 dc phase, 0 ac phase
  input wire logic [15:0] conv_data_i, // Raw converter sample
  output acs_pkg::acs_route_s route_o, // Input routing and gain
  output acs_pkg::acs_sample_s dft_sample_o, // Full-rate to DFT
  output acs_pkg::acs_sample_s decim_sample_o, // Decimated sample
  output acs_pkg::acs_sample_s reject_sample_o // Line reject output
);
  localparam int DIV = `ACS_SAMPLE_DIV;
  localparam int DECIM = `ACS_DECIM_FACTOR;
  localparam int TAPS = `ACS_NOTCH_TAPS;
  acs_pkg::acs_route_s route_d;
  acs_pkg::acs_route_s route_q;
  acs_pkg::acs_phase_e phase_q;
  acs_pkg::acs_phase_e phase_d;
  acs_pkg::acs_sample_s dft_q;
  acs_pkg::acs_sample_s decim_q;
  acs_pkg::acs_sample_s rej_q;
  logic [6:0] div_q;
  logic [7:0] dec_cnt_q;
  logic [23:0] dec_acc_q;
  logic [15:0] hist_q [TAPS];
  logic [20:0] hist_sum_q;
  wire strobe = conv_enable_i && (div_q == 7'(DIV - 1)); // see [RL14]
  wire dec_last = (dec_cnt_q == 8'(DECIM - 1));
  wire [23:0] dec_sum = dec_acc_q + {8'h00, conv_data_i};
  wire [15:0] dec_mean = 16'(dec_sum / 24'(DECIM)); // see [RL16]
  wire [20:0] hist_next = hist_sum_q + {5'h00, dec_mean}
                          - {5'h00, hist_q[TAPS-1]};
  acs_route_decode u_dec (
    .sel_i(converter_config_word_i),
    .route_o(route_d) // see [RL11]
  );
  always_comb
  begin
    phase_d = acs_pkg::ACS_PH_IDLE;
    if (conv_enable_i)
      phase_d = dc_phase_i ? acs_pkg::ACS_PH_DC : acs_pkg::ACS_PH_AC;
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      route_q <= '0;
      phase_q <= acs_pkg::ACS_PH_IDLE;
      div_q <= 7'h00;
    end
    else
    begin
      route_q <= route_d; // see [RL1]
      phase_q <= phase_d;
      div_q <= (!conv_enable_i || strobe) ? 7'h00 : div_q + 7'h01;
    end
  end
  // Full-rate path
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      dft_q <= '0;
    else
    begin
      dft_q.valid <= strobe && (phase_q == acs_pkg::ACS_PH_AC); // see [RL15]
      if (strobe)
        dft_q.data <= conv_data_i;
    end
  end
  // Boxcar decimator
  always_ff @(posedge clk_i)
  begin
    if (reset_i || phase_q != acs_pkg::ACS_PH_DC)
    begin
      dec_cnt_q <= 8'h00;
      dec_acc_q <= 24'h000000;
      decim_q <= '0;
    end
    else
    begin
      decim_q.valid <= strobe && dec_last;
      if (strobe)
      begin
        dec_cnt_q <= dec_last ? 8'h00 : dec_cnt_q + 8'h01;
        dec_acc_q <= dec_last ? 24'h000000 : dec_sum;
        if (dec_last)
          decim_q.data <= dec_mean; // see [RL16]
      end
    end
  end
  // Moving-average line reject: 32 taps at the decimated rate
  genvar gi;
  generate
    for (gi = 0; gi < TAPS; gi++)
    begin : g_hist
      always_ff @(posedge clk_i)
      begin
        if (reset_i)
          hist_q[gi] <= 16'h0000;
        else if (strobe && dec_last && phase_q == acs_pkg::ACS_PH_DC)
          hist_q[gi] <= (gi == 0) ? dec_mean : hist_q[(gi == 0) ? 0 : gi-1];
      end
    end
  endgenerate
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hist_sum_q <= 21'h000000;
      rej_q <= '0;
    end
    else
    begin
      rej_q.valid <= strobe && dec_last && phase_q == acs_pkg::ACS_PH_DC;
      if (strobe && dec_last && phase_q == acs_pkg::ACS_PH_DC)
      begin
        hist_sum_q <= hist_next;
        rej_q.data <= hist_next[20:`ACS_NOTCH_SHIFT]; // see [RL17]
      end
    end
  end
  assign route_o = route_q;
  assign dft_sample_o = dft_q;
  assign decim_sample_o = decim_q;
  assign reject_sample_o = rej_q;
endmodule : acs_channel

// ---- verilog/acs_map.svh ----
// Constants of the converter channel select block
// Assumes inclusion by the design modules acs_channel and acs_route_decode
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_SEL_FLOAT 5'h00
`define ACS_SEL_TIA 5'h02
`define ACS_SEL_TEMP 5'h03
`define ACS_SEL_AUX_A 5'h08
`define ACS_SEL_AUX_D 5'h0B
`define ACS_SEL_REFX 5'h0C
`define ACS_SEL_RAIL_FIRST 5'h0D
`define ACS_SEL_RAIL_LAST 5'h12
`define ACS_SEL_CAL_BIAS 5'h18
`define ACS_SEL_CAL_VREF15 5'h19
`define ACS_SEL_CAL_TNEG 5'h1A
`define ACS_SEL_CAL_ZERO 5'h1C
`define ACS_SEL_CAL_VREF1 5'h1D
`define ACS_SEL_CAL_PN 5'h1E
`define ACS_CLK_PERIOD_NS 100
`define ACS_SAMPLE_RATE_SPS 160000
`define ACS_CLK_HZ 10000000
`define ACS_SAMPLE_DIV (`ACS_CLK_HZ / `ACS_SAMPLE_RATE_SPS)
`define ACS_DECIM_FACTOR 178
`define ACS_NOTCH_TAPS 32
`define ACS_NOTCH_SHIFT 5
`endif

// ---- verilog/acs_pkg.sv ----
// Types of the converter channel select block
// Assumes acs_map.svh for the constants
package acs_pkg;
  typedef enum logic [3:0] {
    ACS_P_NONE = 4'h0, ACS_P_TIA_OUT = 4'h1, ACS_P_TSENS_POS = 4'h2,
    ACS_P_AUX = 4'h3, ACS_P_REFX = 4'h4, ACS_P_RAIL = 4'h5,
    ACS_P_BIAS = 4'h6, ACS_P_VREF = 4'h7, ACS_P_TSENS_NEG = 4'h8,
    ACS_P_ZERO = 4'h9, ACS_P_FE_POS = 4'hA
  } acs_psrc_e;
  typedef enum logic [2:0] {
    ACS_N_NONE = 3'h0, ACS_N_TIA_INV = 3'h1, ACS_N_TSENS_NEG = 3'h2,
    ACS_N_BIAS = 3'h3, ACS_N_FE_NEG = 3'h4
  } acs_nsrc_e;
  typedef struct packed {
    acs_psrc_e pos;
    acs_nsrc_e neg;
    logic [2:0] index;
    logic gain_1p5;
    logic connected;
  } acs_route_s;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } acs_sample_s;
  typedef enum logic [2:0] {
    ACS_PH_IDLE = 3'b001, ACS_PH_AC = 3'b010, ACS_PH_DC = 3'b100
  } acs_phase_e;
endpackage : acs_pkg

// ---- verilog/acs_route_decode.sv ----
// Decodes the 5-bit select code into the input routing and gain
// Assumes a stable code straight from the owning module's select input; the owner registers the result
`timescale 1ns/10ps
`include "acs_map.svh"
module acs_route_decode (
  input wire logic [4:0] sel_i, // Select code
  output acs_pkg::acs_route_s route_o // Routing and gain
);
  always_comb
  begin
    route_o = '{acs_pkg::ACS_P_NONE, acs_pkg::ACS_N_NONE, 3'h0, 1'b0, 1'b0};
    if (sel_i == `ACS_SEL_TIA)
      route_o = '{acs_pkg::ACS_P_TIA_OUT, acs_pkg::ACS_N_TIA_INV, 3'h0,
                  1'b1, 1'b1}; // see [RL2]
    else if (sel_i == `ACS_SEL_TEMP)
      route_o = '{acs_pkg::ACS_P_TSENS_POS, acs_pkg::ACS_N_TSENS_NEG, 3'h0,
                  1'b1, 1'b1}; // see [RL3]
    else if (sel_i >= `ACS_SEL_AUX_A && sel_i <= `ACS_SEL_AUX_D)
      route_o = '{acs_pkg::ACS_P_AUX, acs_pkg::ACS_N_BIAS,
                  sel_i[2:0] - 3'h0, 1'b0, 1'b1}; // see [RL4]
    else if (sel_i == `ACS_SEL_REFX)
      route_o = '{acs_pkg::ACS_P_REFX, acs_pkg::ACS_N_BIAS, 3'h0,
                  1'b0, 1'b1}; // see [RL5]
    else if (sel_i >= `ACS_SEL_RAIL_FIRST && sel_i <= `ACS_SEL_RAIL_LAST)
      route_o = '{acs_pkg::ACS_P_RAIL, acs_pkg::ACS_N_BIAS,
                  3'(sel_i - `ACS_SEL_RAIL_FIRST), 1'b0, 1'b1}; // see [RL6]
    else if (sel_i == `ACS_SEL_CAL_BIAS)
      route_o = '{acs_pkg::ACS_P_BIAS, acs_pkg::ACS_N_BIAS, 3'h0,
                  1'b1, 1'b1}; // see [RL7]
    else if (sel_i == `ACS_SEL_CAL_VREF15)
      route_o = '{acs_pkg::ACS_P_VREF, acs_pkg::ACS_N_BIAS, 3'h0,
                  1'b1, 1'b1}; // see [RL7]
    else if (sel_i == `ACS_SEL_CAL_TNEG)
      route_o = '{acs_pkg::ACS_P_TSENS_NEG, acs_pkg::ACS_N_TSENS_NEG, 3'h0,
                  1'b1, 1'b1}; // see [RL7]
    else if (sel_i == `ACS_SEL_CAL_ZERO)
      route_o = '{acs_pkg::ACS_P_ZERO, acs_pkg::ACS_N_BIAS, 3'h0,
                  1'b0, 1'b1}; // see [RL8]
    else if (sel_i == `ACS_SEL_CAL_VREF1)
      route_o = '{acs_pkg::ACS_P_VREF, acs_pkg::ACS_N_BIAS, 3'h0,
                  1'b0, 1'b1}; // see [RL8]
    else if (sel_i == `ACS_SEL_CAL_PN)
      route_o = '{acs_pkg::ACS_P_FE_POS, acs_pkg::ACS_N_FE_NEG, 3'h0,
                  1'b1, 1'b1}; // see [RL9]
    // Zero code and reserved codes keep the floating default; see [RL1] [RL10]
  end
endmodule : acs_route_decode
